//--- include/stp_pkg.sv
// package: constants, types and helpers of the stepper phase sequencer
package stp_pkg;
  // system clock and bus geometry
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STEPS = 8'h08;

  // control register fields and reset value
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0001;

  // status register field positions
  localparam int unsigned ST_POS_LSB = 0;
  localparam int unsigned ST_EXC_BIT = 3;
  localparam int unsigned ST_EDGE_BIT = 4;
  localparam int unsigned ST_DIR_BIT = 5;
  localparam int unsigned ST_EN_BIT = 6;
  localparam int unsigned ST_FAULT_BIT = 7;
  localparam int unsigned ST_FTYPE_LSB = 8;
  localparam int unsigned ST_FPIN_BIT = 10;
  localparam int unsigned ST_STATE_LSB = 12;
  localparam int unsigned STEPS_W = 16;

  // pin vector positions and synchroniser reset values
  localparam int unsigned PIN_W = 9;
  localparam int unsigned PIN_STEP = 0;
  localparam int unsigned PIN_EXC = 1;
  localparam int unsigned PIN_EDGE = 2;
  localparam int unsigned PIN_DIR = 3;
  localparam int unsigned PIN_SRST = 4;
  localparam int unsigned PIN_EN = 5;
  localparam int unsigned PIN_DOPEN = 6;
  localparam int unsigned PIN_DOC = 7;
  localparam int unsigned PIN_DOH = 8;
  localparam logic [8:0] PIN_RST_VAL = 9'h000;

  // sequencer start: phase a plus phase b-bar
  localparam logic [2:0] POS_INIT = 3'h0;

  // run states of the sequencer
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10,
    ST_FAULT = 2'b11
  } stp_state_t;

  // fault type codes on the two-bit output (none reads as 00)
  typedef enum logic [1:0] {
    FT_NONE = 2'b00,
    FT_OPEN = 2'b01,
    FT_OVERCUR = 2'b10,
    FT_OVERHEAT = 2'b11
  } stp_fault_t;

  // next half-step position; two-phase mode lands on even positions
  function automatic logic [2:0] stp_next_pos(input logic [2:0] pos, input logic half,
                                              input logic ccw);
    logic [2:0] inc;
    inc = (half || pos[0]) ? 3'h1 : 3'h2;
    return ccw ? 3'(pos - inc) : 3'(pos + inc);
  endfunction : stp_next_pos

  // position to phases {a, a_bar, b, b_bar}
  function automatic logic [3:0] stp_phase_map(input logic [2:0] pos);
    logic [3:0] ph;
    case (pos)
      3'h0: ph = 4'h9;
      3'h1: ph = 4'h8;
      3'h2: ph = 4'hA;
      3'h3: ph = 4'h2;
      3'h4: ph = 4'h6;
      3'h5: ph = 4'h4;
      3'h6: ph = 4'h5;
      default: ph = 4'h1;
    endcase
    return ph;
  endfunction : stp_phase_map

  // fault coding, the hottest cause wins when several arrive together
  function automatic stp_fault_t stp_fault_code(input logic open, input logic oc,
                                                input logic oh);
    if (oh) return FT_OVERHEAT;
    else if (oc) return FT_OVERCUR;
    else if (open) return FT_OPEN;
    else return FT_NONE;
  endfunction : stp_fault_code
endpackage : stp_pkg

//--- include/stp_pin_if.sv
// interface: synchronised control and detector pins
`timescale 1ns/1ns
interface stp_pin_if;
  logic step_clk;
  logic excitation_select;
  logic clock_edge_select;
  logic rotation_direction;
  logic system_reset_n;
  logic enable;
  logic det_open;
  logic det_overcur;
  logic det_overheat;
  modport src (output step_clk, excitation_select, clock_edge_select, rotation_direction,
               system_reset_n, enable, det_open, det_overcur, det_overheat);
  modport dst (input step_clk, excitation_select, clock_edge_select, rotation_direction,
               system_reset_n, enable, det_open, det_overcur, det_overheat);
endinterface : stp_pin_if

//--- hdl/stp_pin_sync.sv
// two-flop synchroniser bank for the asynchronous control pins
`timescale 1ns/1ns
module stp_pin_sync (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // raw pins
  input wire logic [stp_pkg::PIN_W-1:0] i_pins,
  // synchronised pins
  stp_pin_if.src o_pins
);
  import stp_pkg::*;

  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] sync_q;
  logic [PIN_W-1:0] meta_d;
  logic [PIN_W-1:0] sync_d;

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  always_comb begin
    meta_d = i_pins;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= PIN_RST_VAL;
      sync_q <= PIN_RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fan out by name
  assign o_pins.step_clk = sync_q[PIN_STEP];
  assign o_pins.excitation_select = sync_q[PIN_EXC];
  assign o_pins.clock_edge_select = sync_q[PIN_EDGE];
  assign o_pins.rotation_direction = sync_q[PIN_DIR];
  assign o_pins.system_reset_n = sync_q[PIN_SRST];
  assign o_pins.enable = sync_q[PIN_EN];
  assign o_pins.det_open = sync_q[PIN_DOPEN];
  assign o_pins.det_overcur = sync_q[PIN_DOC];
  assign o_pins.det_overheat = sync_q[PIN_DOH];
endmodule : stp_pin_sync

//--- hdl/stp_sequencer.sv
// top: stepper phase sequencer with fault latch and wishbone registers
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module stp_sequencer (
  // clock and power-on reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // controller pins
  input wire logic i_step_clk,
  input wire logic i_excitation_select,
  input wire logic i_clock_edge_select,
  input wire logic i_rotation_direction,
  input wire logic i_system_reset_n,
  input wire logic i_enable,
  // fault detectors
  input wire logic i_det_open,
  input wire logic i_det_overcur,
  input wire logic i_det_overheat,
  // phase outputs
  output logic o_phase_a,
  output logic o_phase_a_bar_out,
  output logic o_phase_b,
  output logic o_phase_b_bar_out,
  // fault outputs, summary is open drain
  input wire logic i_fault_summary_n,
  output logic o_fault_summary_n,
  output logic o_fault_summary_n_oe,
  output stp_pkg::stp_fault_t o_fault_type_level,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [stp_pkg::WB_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [stp_pkg::WB_DAT_W-1:0] i_wb_dat,
  output logic [stp_pkg::WB_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack
);
  import stp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops, assertion stays asynchronous
  logic rst_meta_q;
  logic rst_q;
  logic rst_n;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  stp_pin_if p ();

  stp_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_pins({i_det_overheat, i_det_overcur, i_det_open, i_enable, i_system_reset_n,
             i_rotation_direction, i_clock_edge_select, i_excitation_select, i_step_clk}),
    .o_pins(p)
  );

  // summary pin readback, only for status
  logic fpin_meta_q;
  logic fpin_q;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fpin_meta_q <= 1'b1;
      fpin_q <= 1'b1;
    end else begin
      fpin_meta_q <= i_fault_summary_n;
      fpin_q <= fpin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  stp_state_t state_q, state_d;
  logic [2:0] pos_q, pos_d;
  logic step_prev_q, step_prev_d;
  stp_fault_t ftype_q, ftype_d;
  logic [3:0] phase_q, phase_d;
  logic [STEPS_W-1:0] steps_q, steps_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic en;
  logic fault_det;
  logic step_any;
  logic step_rise;
  logic adv;
  logic steps_clr;

  // software gate sits in series with the enable pin
  assign en = p.enable & ctrl_q[CTRL_EN_BIT];
  assign fault_det = p.det_open | p.det_overcur | p.det_overheat;
  assign step_any = p.step_clk ^ step_prev_q;
  assign step_rise = p.step_clk & ~step_prev_q;
  assign adv = p.clock_edge_select ? step_rise : step_any;

  // next-state logic; edge history is frozen in hold and fault like a stopped clock
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    step_prev_d = step_prev_q;
    ftype_d = ftype_q;
    steps_d = steps_clr ? '0 : steps_q;
    if (!p.system_reset_n) begin
      state_d = ST_RESET;
      pos_d = POS_INIT;
      ftype_d = FT_NONE;
      step_prev_d = p.step_clk;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_d = ST_RUN;
          step_prev_d = p.step_clk;
        end
        ST_RUN: begin
          if (!en) begin
            state_d = ST_HOLD;
          end else if (fault_det) begin
            state_d = ST_FAULT;
            ftype_d = stp_fault_code(p.det_open, p.det_overcur, p.det_overheat);
          end else begin
            step_prev_d = p.step_clk;
            if (adv) begin
              pos_d = stp_next_pos(pos_q, p.excitation_select, p.rotation_direction);
              // a step in the clear cycle still counts
              steps_d = steps_clr ? STEPS_W'(1) : STEPS_W'(steps_q + 1'b1);
            end
          end
        end
        ST_HOLD: begin
          if (en) state_d = ST_RUN;
        end
        ST_FAULT: begin
          state_d = ST_FAULT;
        end
        default: begin
          state_d = ST_RESET;
        end
      endcase
    end
    // drive phases only while running and enabled
    phase_d = (state_d == ST_RUN && en) ? stp_phase_map(pos_d) : 4'h0;
  end

  // power-on reset lands in the same state as a system reset
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      pos_q <= POS_INIT;
      step_prev_q <= 1'b0;
      ftype_q <= FT_NONE;
      phase_q <= 4'h0;
      steps_q <= '0;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
      step_prev_q <= step_prev_d;
      ftype_q <= ftype_d;
      phase_q <= phase_d;
      steps_q <= steps_d;
    end
  end

  // phase and fault pins
  assign {o_phase_a, o_phase_a_bar_out, o_phase_b, o_phase_b_bar_out} = phase_q;
  assign o_fault_summary_n = 1'b0;
  assign o_fault_summary_n_oe = (state_q == ST_FAULT);
  assign o_fault_type_level = ftype_q;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone classic slave, one wait state, unmapped reads zero
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic wr_take;
  logic [31:0] status;

  assign wr_take = i_wb_cyc & i_wb_stb & i_wb_we & ack_q;
  assign steps_clr = wr_take && (i_wb_adr == REG_STEPS);

  always_comb begin
    status = '0;
    status[ST_POS_LSB +: 3] = pos_q;
    status[ST_EXC_BIT] = p.excitation_select;
    status[ST_EDGE_BIT] = p.clock_edge_select;
    status[ST_DIR_BIT] = p.rotation_direction;
    status[ST_EN_BIT] = en;
    status[ST_FAULT_BIT] = (state_q == ST_FAULT);
    status[ST_FTYPE_LSB +: 2] = ftype_q;
    status[ST_FPIN_BIT] = fpin_q;
    status[ST_STATE_LSB +: 2] = state_q;
  end

  // ack drops the cycle after it was given
  always_comb begin
    ack_d = i_wb_cyc & i_wb_stb & ~ack_q;
    rdat_d = '0;
    ctrl_d = ctrl_q;
    if (i_wb_adr == REG_CTRL) begin
      rdat_d = ctrl_q;
    end else if (i_wb_adr == REG_STATUS) begin
      rdat_d = status;
    end else if (i_wb_adr == REG_STEPS) begin
      rdat_d = 32'(steps_q);
    end else begin
      rdat_d = '0;
    end
    if (wr_take && i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
      ctrl_d = {31'h0, i_wb_dat[CTRL_EN_BIT]};
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= CTRL_RST_VAL;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic run_adv;
  assign run_adv = (state_q == ST_RUN) && en && !fault_det && adv && p.system_reset_n;

  half_step_fwd_a: assert property (
    run_adv && p.excitation_select && !p.rotation_direction
    |=> pos_q == 3'($past(pos_q) + 3'h1)) else $error("half step cw wrong");
  two_phase_even_a: assert property (
    run_adv && !p.excitation_select
    |=> pos_q[0] == 1'b0 && pos_q != $past(pos_q)) else $error("two-phase odd");
  rise_only_a: assert property (
    (state_q == ST_RUN) && en && p.system_reset_n
    && p.clock_edge_select && !p.step_clk && step_prev_q
    |=> $stable(pos_q)) else $error("falling edge stepped");
  ccw_order_a: assert property (
    run_adv && p.excitation_select && p.rotation_direction
    |=> pos_q == 3'($past(pos_q) - 3'h1)) else $error("ccw order wrong");
  reset_init_a: assert property (
    !p.system_reset_n
    |=> state_q == ST_RESET && pos_q == POS_INIT ##2 phase_q inside {4'h0, 4'h9})
    else $error("reset start wrong");
  enable_off_a: assert property (!en |=> phase_q == 4'h0) else $error("phase on in disable");
  hold_keep_a: assert property (
    state_q == ST_HOLD && p.system_reset_n
    |=> $stable(pos_q) && $stable(ftype_q)) else $error("hold changed state");
  fault_latch_a: assert property (
    (state_q == ST_RUN) && en && fault_det && p.system_reset_n
    |=> o_fault_summary_n_oe && phase_q == 4'h0) else $error("fault not latched");
  fault_heat_a: assert property (
    (state_q == ST_RUN) && en && p.det_overheat && p.system_reset_n
    |=> o_fault_type_level == FT_OVERHEAT) else $error("bad type");
  fault_sticky_a: assert property (
    state_q == ST_FAULT && p.system_reset_n
    |=> state_q == ST_FAULT && $stable(ftype_q) && phase_q == 4'h0)
    else $error("fault cleared");
  wb_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack timing wrong");

  step_half_c: cover property (run_adv && p.excitation_select);
  hold_resume_c: cover property (state_q == ST_HOLD ##1 state_q == ST_RUN);
  fault_seen_c: cover property (state_q == ST_RUN ##1 state_q == ST_FAULT);
endmodule : stp_sequencer

//--- sim/stp_ctrl_model.sv
// partner: motion controller driving the step, mode, reset and enable pins
`timescale 1ns/1ns
module stp_ctrl_model (
  // clock
  input wire logic i_clk_sys,
  // controller pins
  output logic o_step_clk,
  output logic o_excitation_select,
  output logic o_clock_edge_select,
  output logic o_rotation_direction,
  output logic o_system_reset_n,
  output logic o_enable
);
  // level holds in 8 ns cycles: 10 us single edge, 20 us high and 30 us low on both edges
  localparam int SGL_LVL = 1250;
  localparam int BTH_HI = 2500;
  localparam int BTH_LO = 3750;
  localparam int MODE_GAP = 800; // longer than 6.25 us
  localparam int RST_GAP = 1250;
  //////////////////////////////////////////////////////////////////////////////
  // idle levels; system reset stays low until the bench releases it
  initial begin
    o_step_clk = 1'b0;
    o_excitation_select = 1'b1;
    o_clock_edge_select = 1'b1;
    o_rotation_direction = 1'b0;
    o_system_reset_n = 1'b0;
    o_enable = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one full step clock period, level times follow the edge mode
  task automatic pulse();
    @(posedge i_clk_sys);
    o_step_clk <= 1'b1;
    repeat (o_clock_edge_select ? SGL_LVL : BTH_HI) @(posedge i_clk_sys);
    o_step_clk <= 1'b0;
    repeat (o_clock_edge_select ? SGL_LVL : BTH_LO) @(posedge i_clk_sys);
  endtask : pulse
  // mode and direction change only far from any step edge
  task automatic set_mode(input logic h, input logic e, input logic d);
    repeat (MODE_GAP) @(posedge i_clk_sys);
    o_excitation_select <= h;
    o_clock_edge_select <= e;
    o_rotation_direction <= d;
    repeat (MODE_GAP) @(posedge i_clk_sys);
  endtask : set_mode
  // low for 6 cycles then high on system reset, then a settle gap before stepping
  task automatic sys_reset();
    @(posedge i_clk_sys);
    o_system_reset_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    o_system_reset_n <= 1'b1;
    repeat (RST_GAP) @(posedge i_clk_sys);
  endtask : sys_reset
  // enable change; the wait covers the pin synchroniser
  task automatic set_en(input logic v);
    @(posedge i_clk_sys);
    o_enable <= v;
    repeat (16) @(posedge i_clk_sys);
  endtask : set_en
endmodule : stp_ctrl_model

//--- sim/stp_sequencer_tb.sv
// bench: sequencer driven by the controller model, registers over wishbone
`timescale 1ns/1ns
module stp_sequencer_tb;
  import stp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic step, exc, edg, dir, srst_n, en;
  logic d_open = 1'b0;
  logic d_oc = 1'b0;
  logic d_oh = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [WB_ADR_W-1:0] adr = '0;
  logic [WB_DAT_W-1:0] wdat = '0;
  logic [3:0] sel = 4'h0;
  logic [WB_DAT_W-1:0] rdat;
  logic ack, pa, pab, pb, pbb, fs_n, fs_oe, fs_wire;
  stp_fault_t ftype;
  logic [3:0] ph;
  logic [31:0] rd;
  logic [2:0] pos = 3'h0;
  logic half = 1'b1;
  logic ccw = 1'b0;
  logic both = 1'b0;
  int n_errors = 0;
  int checks_done = 0;
  // phase nibble {a, a_bar, b, b_bar} per position, position 0 lowest
  localparam logic [31:0] PH_TBL = 32'h1546_2A89;
  //////////////////////////////////////////////////////////////////////////////
  // clock, pulled-up summary wire and phase vector
  always #4 clk = ~clk;
  assign fs_wire = fs_oe ? fs_n : 1'b1;
  assign ph = {pa, pab, pb, pbb};
  stp_ctrl_model stp_ctrl_model_inst (.i_clk_sys(clk), .o_step_clk(step),
    .o_excitation_select(exc), .o_clock_edge_select(edg), .o_rotation_direction(dir),
    .o_system_reset_n(srst_n), .o_enable(en));
  stp_sequencer stp_sequencer_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_step_clk(step),
    .i_excitation_select(exc), .i_clock_edge_select(edg), .i_rotation_direction(dir),
    .i_system_reset_n(srst_n), .i_enable(en), .i_det_open(d_open), .i_det_overcur(d_oc),
    .i_det_overheat(d_oh), .o_phase_a(pa), .o_phase_a_bar_out(pab), .o_phase_b(pb),
    .o_phase_b_bar_out(pbb), .i_fault_summary_n(fs_wire), .o_fault_summary_n(fs_n),
    .o_fault_summary_n_oe(fs_oe), .o_fault_type_level(ftype), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack));
  //////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // classic single cycle; waits on ack under a bound, read data taken at that edge
  task automatic wb(input logic w, input logic [WB_ADR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
  endtask : wb
  // expected next position, independent of the design's helpers
  function automatic logic [2:0] nxt(input logic [2:0] p);
    logic [2:0] d;
    d = (half || p[0]) ? 3'h1 : 3'h2;
    return ccw ? 3'(p - d) : 3'(p + d);
  endfunction : nxt
  // step pulses, each followed by a phase comparison
  task automatic steps(input int n);
    repeat (n) begin
      stp_ctrl_model_inst.pulse();
      pos = nxt(pos);
      if (both) pos = nxt(pos);
      chk({28'h0, ph}, {28'h0, PH_TBL[{pos, 2'b00} +: 4]});
    end
  endtask : steps
  task automatic mode(input logic h, input logic e, input logic d);
    stp_ctrl_model_inst.set_mode(h, e, d);
    half = h;
    both = ~e;
    ccw = d;
  endtask : mode
  // detector pulse of type k: 0 open, 1 overcurrent, 2 overheat
  task automatic fault(input int k);
    @(posedge clk);
    {d_open, d_oc, d_oh} <= {k == 0, k == 1, k == 2};
    repeat (6) @(posedge clk);
    {d_open, d_oc, d_oh} <= 3'b000;
    repeat (8) @(posedge clk);
  endtask : fault
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////////
  // watchdog; the tests need roughly 70k cycles
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    stp_ctrl_model_inst.sys_reset();
    chk({28'h0, ph}, 32'h9);
    chk({28'h0, fs_oe, fs_wire, ftype}, 32'h4);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(rd, CTRL_RST_VAL);
    $display("test reset done");
    wb(1'b1, REG_STEPS, 32'h0);
    steps(8);
    wb(1'b0, REG_STEPS, 32'h0);
    chk(rd, 32'h8);
    mode(1'b0, 1'b1, 1'b1);
    steps(4);
    mode(1'b1, 1'b0, 1'b0);
    steps(2);
    mode(1'b1, 1'b1, 1'b1);
    steps(2);
    $display("test sequencing done");
    stp_ctrl_model_inst.set_en(1'b0);
    chk({28'h0, ph}, 32'h0);
    stp_ctrl_model_inst.pulse();
    chk({28'h0, ph}, 32'h0);
    stp_ctrl_model_inst.set_en(1'b1);
    chk({28'h0, ph}, {28'h0, PH_TBL[{pos, 2'b00} +: 4]});
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    chk({28'h0, ph}, 32'h0);
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    chk({28'h0, ph}, {28'h0, PH_TBL[{pos, 2'b00} +: 4]});
    steps(1);
    $display("test enable done");
    for (int k = 0; k < 3; k++) begin
      fault(k);
      chk({28'h0, fs_oe, fs_wire, ftype}, {28'h0, 2'b10, 2'(k + 1)});
      stp_ctrl_model_inst.pulse();
      chk({28'h0, ph}, 32'h0);
      wb(1'b0, REG_STATUS, 32'h0);
      chk({30'h0, rd[ST_STATE_LSB +: 2]}, 32'h3);
      chk({28'h0, rd[ST_FPIN_BIT], rd[ST_FAULT_BIT], rd[ST_FTYPE_LSB +: 2]},
          {28'h0, 2'b01, 2'(k + 1)});
      stp_ctrl_model_inst.sys_reset();
      pos = 3'h0;
      chk({24'h0, ph, fs_oe, fs_wire, ftype}, 32'h94);
    end
    fault(2);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (24) @(posedge clk);
    chk({24'h0, ph, fs_oe, fs_wire, ftype}, 32'h94);
    $display("test faults done");
    end_of_test();
  end
endmodule : stp_sequencer_tb
